/* common/flash_pin_consts.vh */
// constants for the serial flash pin interface and its page buffer
`ifndef FLASH_PIN_CONSTS_VH
`define FLASH_PIN_CONSTS_VH

// ------------------------------------------------------------------
// command opcodes (eight bits, sent first after select)
// ------------------------------------------------------------------
`define OP_BUF_WRITE    8'h84
`define OP_BUF_READ     8'hD4
`define OP_BUF_PROGRAM  8'h83
`define OP_PAGE_ERASE   8'h81
`define OP_STATUS_READ  8'hD7
`define OP_PROT_ENABLE  8'h3D
`define OP_PROT_DISABLE 8'h3E
`define OP_PROT_WRITE   8'h3F
`define OP_SECTOR_LOCK  8'h30
`define OP_PAGE_BINARY  8'hA6

// ------------------------------------------------------------------
// sizes and field positions
// ------------------------------------------------------------------
`define PAGE_SIZE_DEF   9'h108
`define PAGE_SIZE_BIN   9'h100
`define PAGE_COUNT      11'h400
`define BUF_DEPTH       264
`define BUF_AW          9
`define ADDR_LAST_BYTE  2'h2
`define BIT_LAST        3'h7
`define BIT_FIRST       3'h7
`define SECT_HI         9
`define SECT_LO         7
`define ST_READY_BIT    7
`define ST_WP_BIT       6
`define ST_PROT_BIT     5
`define ST_REFUSE_BIT   4
`define ST_PAGE_BIT     0

// ------------------------------------------------------------------
// timing: clock rate, self-timed cycle lengths, power-on hold
// ------------------------------------------------------------------
`define CLK_FREQ_MHZ    25
`define PROG_TIME_US    100
`define ERASE_TIME_US   150
`define PROG_CYCLES     (`PROG_TIME_US * `CLK_FREQ_MHZ)
`define ERASE_CYCLES    (`ERASE_TIME_US * `CLK_FREQ_MHZ)
`define POR_CYCLES      5'h10

`endif

/* verilog/page_buffer_ram.v */
// single page buffer memory with registered read data
`timescale 1ns/100ps
module page_buffer_ram (
    input  wire       clk,      // system clock
    input  wire       we,       // write strobe
    input  wire [8:0] waddr,    // write byte address
    input  wire [7:0] wdata,    // write byte
    input  wire [8:0] raddr,    // read byte address
    output reg  [7:0] rdata     // registered read byte
);
`include "flash_pin_consts.vh"

    // ------------------------------------------------------------------
    // storage
    // ------------------------------------------------------------------
    reg [7:0] mem [0:`BUF_DEPTH-1];   // buffer bytes

    // writes beyond the largest page are dropped rather than aliased
    always @(posedge clk) begin
        if (we && (waddr < `BUF_DEPTH)) begin
            mem[waddr] <= wdata;
        end
    end

    // read data always comes out of a register
    always @(posedge clk) begin
        if (raddr < `BUF_DEPTH) begin
            rdata <= mem[raddr];
        end else begin
            rdata <= 8'h00;
        end
    end

endmodule // page_buffer_ram

/* verilog/serial_flash_pin_interface.v */
// serial flash pin interface: framing, shifting, protection, reset
//
// Functional notes
// RULE_01: deselected means standby, output released
// RULE_02: input line ignored while deselected
// RULE_03: host frames each operation with select
// RULE_04: select rise during cycle keeps device active
// RULE_05: input bits sampled on clock rise
// RULE_06: output bit changes on clock fall
// RULE_07: write-protect low shields marked sectors
// RULE_08: protection mask frozen while write-protect low
// RULE_09: program/erase under write-protect is discarded
// RULE_10: protect enable and lockdown still accepted
// RULE_11: write-protect defaults high when floating (the code only presets the synchroniser high during reset)
// RULE_12: reset pin low aborts and holds idle
// RULE_13: internal power-on reset, no pin sequence
// RULE_14: clock modes 0 and 3 both work
// RULE_15: page size 256 or 264, default 264
// RULE_16: main array holds 1024 pages
// RULE_17: program and erase are self-timed
// RULE_18: all fields shifted msb first
// RULE_19: host sends opcode then address bytes
// RULE_20: select fall clears bit and byte counters
`timescale 1ns/100ps
module serial_flash_pin_interface (
    input  wire clk,        // system clock, 25 MHz
    input  wire reset,      // synchronous reset, active high
    input  wire cs_n,       // chip select pin, active low
    input  wire sck,        // serial clock pin
    input  wire si,         // serial data in pin
    input  wire wp_n,       // write protect pin, active low
    input  wire hw_reset_n, // hardware reset pin, active low
    output reg  so,         // serial data out
    output reg  so_oe,      // output enable for serial data out
    output reg  standby,    // high while idle and deselected
    output reg  busy        // high during a self-timed cycle
);
`include "flash_pin_consts.vh"

    // ------------------------------------------------------------------
    // states and local constants
    // ------------------------------------------------------------------
    localparam [2:0] ST_OPC    = 3'h0;  // waiting for opcode
    localparam [2:0] ST_ADDR   = 3'h1;  // taking address bytes
    localparam [2:0] ST_DATA   = 3'h2;  // taking data bytes
    localparam [2:0] ST_DUMMY  = 3'h3;  // one dummy byte before output
    localparam [2:0] ST_OUT    = 3'h4;  // shifting data out
    localparam [2:0] ST_IGNORE = 3'h5;  // discard until deselect
    localparam [1:0] PEND_NONE = 2'h0;  // nothing to start
    localparam [1:0] PEND_PROG = 2'h1;  // program on deselect
    localparam [1:0] PEND_ERAS = 2'h2;  // erase on deselect
    localparam integer PROG_FULL  = `PROG_CYCLES;   // program length, full width
    localparam integer ERASE_FULL = `ERASE_CYCLES;  // erase length, full width
    localparam [11:0] PROG_CNT  = PROG_FULL[11:0];
    localparam [11:0] ERASE_CNT = ERASE_FULL[11:0];

    // ------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------
    reg        cs_n_meta, cs_n_sync;   // select
    reg        sck_meta,  sck_sync;    // serial clock
    reg        si_meta,   si_sync;     // serial input
    reg        wp_n_meta, wp_n_sync;   // write protect
    reg        rst_meta,  rst_sync;    // reset pin, high = run
    reg        cs_n_dly_reg;           // previous select for edges
    reg        sck_dly_reg;            // previous clock for edges

    // every pin is asynchronous to clk, so two stages before use
    always @(posedge clk) begin
        if (reset) begin
            cs_n_meta <= 1'b1;
            cs_n_sync <= 1'b1;
            sck_meta  <= 1'b0;
            sck_sync  <= 1'b0;
            si_meta   <= 1'b0;
            si_sync   <= 1'b0;
            // RULE_11: protect reads high only while in reset; after that the pin is sampled as it is driven
            wp_n_meta <= 1'b1;
            wp_n_sync <= 1'b1;
            rst_meta  <= 1'b1;
            rst_sync  <= 1'b1;
            cs_n_dly_reg <= 1'b1;
            sck_dly_reg  <= 1'b0;
        end else begin
            cs_n_meta <= cs_n;
            cs_n_sync <= cs_n_meta;
            sck_meta  <= sck;
            sck_sync  <= sck_meta;
            si_meta   <= si;
            si_sync   <= si_meta;
            wp_n_meta <= wp_n;
            wp_n_sync <= wp_n_meta;
            rst_meta  <= hw_reset_n;
            rst_sync  <= rst_meta;
            cs_n_dly_reg <= cs_n_sync;
            sck_dly_reg  <= sck_sync;
        end
    end

    // ------------------------------------------------------------------
    // edge detection
    // ------------------------------------------------------------------
    // RULE_14: edges only count while selected, so idle level is free
    wire sck_rise = sck_sync & ~sck_dly_reg & ~cs_n_sync;
    wire sck_fall = ~sck_sync & sck_dly_reg & ~cs_n_sync;
    wire cs_fall  = ~cs_n_sync & cs_n_dly_reg;
    wire cs_rise  = cs_n_sync & ~cs_n_dly_reg;

    // ------------------------------------------------------------------
    // internal power-on reset
    // ------------------------------------------------------------------
    reg  [4:0] por_cnt_reg;   // hold counter after system reset

    // RULE_13: the device holds itself idle for a while on its own
    always @(posedge clk) begin
        if (reset) begin
            por_cnt_reg <= 5'h00;
        end else if (por_cnt_reg != `POR_CYCLES) begin
            por_cnt_reg <= por_cnt_reg + 5'h01;
        end
    end

    // RULE_12: pin reset joins the internal reset for as long as it lasts
    wire dev_rst = reset | ~rst_sync | (por_cnt_reg != `POR_CYCLES);

    // ------------------------------------------------------------------
    // state registers
    // ------------------------------------------------------------------
    reg  [2:0]  state_reg;       // frame state
    reg  [2:0]  bit_cnt_reg;     // bit within byte
    reg  [1:0]  byte_cnt_reg;    // address byte count
    reg  [6:0]  shift_reg;       // bits taken so far
    reg  [7:0]  opcode_reg;      // current opcode
    reg  [15:0] addr_reg;        // first address bytes
    reg  [8:0]  buf_ptr_reg;     // buffer byte pointer
    reg  [9:0]  page_reg;        // target page for program/erase
    reg  [1:0]  pend_reg;        // cycle to start on deselect
    reg  [11:0] busy_cnt_reg;    // self-timed cycle count
    reg         page_bin_reg;    // 1 = 256-byte pages
    reg         prot_en_reg;     // software protection on
    reg  [7:0]  prot_mask_reg;   // sector protection marks
    reg  [7:0]  lock_reg;        // permanently locked sectors
    reg         refused_reg;     // last program/erase or mask write refused
    reg  [2:0]  out_bit_reg;     // output bit index
    reg         out_status_reg;  // output source is status
    reg         ram_we_reg;      // buffer write strobe
    reg  [7:0]  ram_wd_reg;      // buffer write byte
    reg  [8:0]  ram_wa_reg;      // buffer write address
    wire [7:0]  ram_rdata;       // buffer read byte

    // ------------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------------
    // RULE_18: msb arrives first, newest bit lands at the bottom
    wire [7:0]  byte_in   = {shift_reg, si_sync};
    wire [23:0] addr_full = {addr_reg, byte_in};
    // RULE_15: page size follows the configuration bit
    wire [8:0]  page_size = page_bin_reg ? `PAGE_SIZE_BIN : `PAGE_SIZE_DEF;
    wire [8:0]  addr_byte = page_bin_reg ? {1'b0, addr_full[7:0]}
                                         : addr_full[8:0];
    // RULE_16: ten page bits address 1024 pages either way
    wire [9:0]  addr_page = page_bin_reg ? addr_full[17:8] : addr_full[18:9];
    wire [8:0]  ptr_plus  = buf_ptr_reg + 9'h001;
    // the buffer wraps at the current page size
    wire [8:0]  ptr_next  = (ptr_plus == page_size) ? 9'h000 : ptr_plus;
    wire [2:0]  sect      = page_reg[`SECT_HI:`SECT_LO];
    // RULE_07: protect pin low forces the mask active
    wire        sect_blk  = lock_reg[sect] |
                            ((prot_en_reg | ~wp_n_sync) & prot_mask_reg[sect]);
    wire [2:0]  addr_sect = addr_page[`SECT_HI:`SECT_LO];
    wire        is_pe     = (byte_in == `OP_BUF_PROGRAM) |
                            (byte_in == `OP_PAGE_ERASE);
    // a cycle starting on this deselect must not flash standby for one clock
    wire        cycle_go  = cs_rise & (pend_reg != PEND_NONE) & ~sect_blk;

    // status byte, read repeatedly while clocked
    wire [7:0] status;
    assign status[`ST_READY_BIT]  = ~busy;
    assign status[`ST_WP_BIT]     = wp_n_sync;
    assign status[`ST_PROT_BIT]   = prot_en_reg;
    assign status[`ST_REFUSE_BIT] = refused_reg;
    assign status[3:1]            = 3'h0;
    assign status[`ST_PAGE_BIT]   = page_bin_reg;
    wire [7:0] out_byte = out_status_reg ? status : ram_rdata;

    // ------------------------------------------------------------------
    // page buffer
    // ------------------------------------------------------------------
    page_buffer_ram u_buf (
        .clk   (clk),
        .we    (ram_we_reg),
        .waddr (ram_wa_reg),
        .wdata (ram_wd_reg),
        .raddr (buf_ptr_reg),
        .rdata (ram_rdata)
    );

    // ------------------------------------------------------------------
    // main frame engine
    // ------------------------------------------------------------------
    always @(posedge clk) begin
        if (dev_rst) begin
            // RULE_12: everything returns to idle, cycles abort
            state_reg      <= ST_OPC;
            bit_cnt_reg    <= 3'h0;
            byte_cnt_reg   <= 2'h0;
            shift_reg      <= 7'h00;
            opcode_reg     <= 8'h00;
            addr_reg       <= 16'h0000;
            buf_ptr_reg    <= 9'h000;
            page_reg       <= 10'h000;
            pend_reg       <= PEND_NONE;
            busy_cnt_reg   <= 12'h000;
            busy           <= 1'b0;
            refused_reg    <= 1'b0;
            out_bit_reg    <= `BIT_FIRST;
            out_status_reg <= 1'b0;
            ram_we_reg     <= 1'b0;
            ram_wd_reg     <= 8'h00;
            ram_wa_reg     <= 9'h000;
            so             <= 1'b0;
            so_oe          <= 1'b0;
            standby        <= 1'b1;
            if (reset) begin
                // configuration survives a pin reset, not a system reset
                page_bin_reg  <= 1'b0;
                prot_en_reg   <= 1'b0;
                prot_mask_reg <= 8'h00;
                lock_reg      <= 8'h00;
            end
        end else begin
            ram_we_reg <= 1'b0;
            // RULE_04: deselect alone never ends a running cycle
            standby    <= cs_n_sync & ~busy & ~cycle_go;
            // RULE_17: cycle counts down on clk with no serial clock
            if (busy) begin
                if (busy_cnt_reg == 12'h001) begin
                    busy <= 1'b0;
                end
                busy_cnt_reg <= busy_cnt_reg - 12'h001;
            end
            // deselect completes a program or erase command
            if (cs_rise && (pend_reg != PEND_NONE)) begin
                if (sect_blk) begin
                    refused_reg <= 1'b1;
                end else begin
                    busy         <= 1'b1;
                    busy_cnt_reg <= (pend_reg == PEND_PROG) ? PROG_CNT : ERASE_CNT;
                end
                pend_reg <= PEND_NONE;
            end
            if (cs_n_sync) begin
                // RULE_01: output released while deselected
                // RULE_02: nothing is captured from the input line
                state_reg   <= ST_OPC;
                bit_cnt_reg <= 3'h0;
                so_oe       <= 1'b0;
                so          <= 1'b0;
            end else if (cs_fall) begin
                // RULE_20: new frame starts at bit seven of an opcode
                state_reg    <= ST_OPC;
                bit_cnt_reg  <= 3'h0;
                byte_cnt_reg <= 2'h0;
                pend_reg     <= PEND_NONE;
            end else if (sck_rise) begin
                // RULE_05: one input bit per rising edge
                shift_reg   <= byte_in[6:0];
                bit_cnt_reg <= bit_cnt_reg + 3'h1;
                if (bit_cnt_reg == `BIT_LAST) begin
                    case (state_reg)
                    // RULE_19: first byte of a frame is the opcode
                    ST_OPC: begin
                        opcode_reg   <= byte_in;
                        byte_cnt_reg <= 2'h0;
                        state_reg    <= ST_IGNORE;
                        if (byte_in == `OP_STATUS_READ) begin
                            state_reg      <= ST_OUT;
                            out_status_reg <= 1'b1;
                            out_bit_reg    <= `BIT_FIRST;
                            so_oe          <= 1'b1;
                        end else if (busy) begin
                            // only status is served during a cycle
                            state_reg <= ST_IGNORE;
                        end else if (is_pe && !wp_n_sync) begin
                            // RULE_09: discarded, idle again on deselect
                            refused_reg <= 1'b1;
                        end else if (byte_in == `OP_PROT_ENABLE) begin
                            // RULE_10: accepted regardless of protect pin
                            prot_en_reg <= 1'b1;
                        end else if (byte_in == `OP_PROT_DISABLE) begin
                            prot_en_reg <= 1'b0;
                        end else if (byte_in == `OP_PAGE_BINARY) begin
                            page_bin_reg <= 1'b1;
                        end else if (byte_in == `OP_PROT_WRITE) begin
                            state_reg <= ST_DATA;
                        end else if (is_pe ||
                                     (byte_in == `OP_BUF_WRITE) ||
                                     (byte_in == `OP_BUF_READ) ||
                                     (byte_in == `OP_SECTOR_LOCK)) begin
                            if (is_pe) begin
                                refused_reg <= 1'b0;
                            end
                            state_reg <= ST_ADDR;
                        end
                    end
                    ST_ADDR: begin
                        addr_reg     <= addr_full[15:0];
                        byte_cnt_reg <= byte_cnt_reg + 2'h1;
                        if (byte_cnt_reg == `ADDR_LAST_BYTE) begin
                            buf_ptr_reg <= addr_byte;
                            page_reg    <= addr_page;
                            state_reg   <= ST_IGNORE;
                            if (opcode_reg == `OP_BUF_WRITE) begin
                                state_reg <= ST_DATA;
                            end else if (opcode_reg == `OP_BUF_READ) begin
                                state_reg <= ST_DUMMY;
                            end else if (opcode_reg == `OP_BUF_PROGRAM) begin
                                pend_reg <= PEND_PROG;
                            end else if (opcode_reg == `OP_PAGE_ERASE) begin
                                pend_reg <= PEND_ERAS;
                            end else begin
                                // RULE_10: lockdown works with protect low
                                lock_reg[addr_sect] <= 1'b1;
                            end
                        end
                    end
                    ST_DATA: begin
                        if (opcode_reg == `OP_PROT_WRITE) begin
                            // RULE_08: mask is frozen while protect is low
                            if (wp_n_sync) begin
                                prot_mask_reg <= byte_in;
                            end else begin
                                refused_reg <= 1'b1;
                            end
                            state_reg <= ST_IGNORE;
                        end else begin
                            ram_we_reg  <= 1'b1;
                            ram_wa_reg  <= buf_ptr_reg;
                            ram_wd_reg  <= byte_in;
                            buf_ptr_reg <= ptr_next;
                        end
                    end
                    ST_DUMMY: begin
                        // buffer read data settles long before the next fall
                        state_reg      <= ST_OUT;
                        out_status_reg <= 1'b0;
                        out_bit_reg    <= `BIT_FIRST;
                        so_oe          <= 1'b1;
                    end
                    default: begin
                        // output and ignore phases take no input bytes
                        state_reg <= state_reg;
                    end
                    endcase
                end
            end else if (sck_fall && (state_reg == ST_OUT)) begin
                // RULE_06: next output bit on the falling edge, msb first
                so          <= out_byte[out_bit_reg];
                out_bit_reg <= out_bit_reg - 3'h1;
                if ((out_bit_reg == 3'h0) && !out_status_reg) begin
                    buf_ptr_reg <= ptr_next;
                end
            end
        end
    end

endmodule // serial_flash_pin_interface

/* tb/flash_pin_checker.sv */
// port assertions for the serial flash pin interface
`timescale 1ns/100ps
module flash_pin_checker (
    input wire logic clk,        // system clock
    input wire logic reset,      // sync reset
    input wire logic cs_n,       // select pin
    input wire logic sck,        // serial clock pin
    input wire logic si,         // data in pin
    input wire logic wp_n,       // write protect pin
    input wire logic hw_reset_n, // reset pin
    input wire logic so,         // data out
    input wire logic so_oe,      // data out enable
    input wire logic standby,    // idle flag
    input wire logic busy        // self-timed flag
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    logic [12:0] len_reg;  // cycles spent busy so far
    logic [12:0] len_next; // next busy length
    // counts a self-timed cycle so its length is judged where it ends
    always_comb len_next = busy ? len_reg + 13'h1 : 13'h0;
    always_ff @(posedge clk) len_reg <= reset ? 13'h0 : len_next;
    // waits of six cycles cover the two-stage pin synchronisers
    a_desel_so_off: assert property (cs_n [*6] |-> !so_oe)
        else $error("output enabled while deselected");
    a_released_low: assert property (!so_oe |-> !so)
        else $error("released output not low");
    a_idle_standby: assert property (cs_n [*6] ##0 (!busy && !$past(busy)) |-> standby)
        else $error("no standby while deselected and idle");
    a_sel_active: assert property (!cs_n [*6] |-> !standby)
        else $error("standby while selected");
    a_busy_active: assert property (busy |-> !standby)
        else $error("standby during self-timed cycle");
    a_so_on_fall: assert property (so_oe && $past(so_oe, 3) && $changed(so) |-> !$past(sck, 2))
        else $error("output changed away from clock fall");
    a_abort_idle: assert property (!hw_reset_n [*6] |-> !busy && !so_oe)
        else $error("reset pin did not force idle");
    a_busy_start: assert property ($rose(busy) |-> cs_n && wp_n)
        else $error("cycle started while selected or protected");
    a_busy_length: assert property ($fell(busy) && hw_reset_n |-> len_reg inside {[2499:2501], [3749:3751]})
        else $error("self-timed cycle length wrong");
    c_cycle: cover property ($rose(busy));
    c_output: cover property ($rose(so_oe));
    c_abort: cover property (!hw_reset_n && busy);
endmodule // flash_pin_checker

/* tb/spi_host_model.sv */
// host side model: drives select, serial clock and data in, reads data out
`timescale 1ns/100ps
module spi_host_model (
    input  wire logic clk,   // system clock
    output logic      cs_n,  // chip select
    output logic      sck,   // serial clock
    output logic      si,    // data to device
    input  wire logic so,    // data from device
    input  wire logic so_oe  // device drives so
);
    logic mode3 = 1'b0; // idle clock high when set
    int   nb = 8;       // bits per transfer, fewer for a cut-off byte
    initial begin
        cs_n = 1'b1;
        sck = 1'b0;
        si = 1'b0;
    end
    // half of a 320 ns serial clock period
    task automatic half;
        repeat (4) @(negedge clk);
    endtask
    // select falls, clock parked at its idle level
    task automatic start;
        @(negedge clk);
        sck = mode3;
        half();
        cs_n = 1'b0;
        half();
    endtask
    // msb first, set on low clock, read at rise
    task automatic xfer(input logic [7:0] d, output logic [7:0] r);
        for (int i = 7; i > 7 - nb; i--) begin
            sck = 1'b0;
            si = d[i];
            half();
            sck = 1'b1;
            r[i] = so_oe ? so : 1'bx; // an undriven line is never trusted
            half();
        end
    endtask
    // select rises; data line shows the inverse once released
    task automatic stop;
        sck = mode3;
        half();
        cs_n = 1'b1;
        si = ~si;
        repeat (2) half();
    endtask
    // clock and data wiggle while deselected
    task automatic noise;
        for (int i = 0; i < 8; i++) begin
            sck = ~sck;
            si = ~si;
            half();
        end
        sck = mode3;
    endtask
endmodule // spi_host_model

/* tb/tb.sv */
// self-checking bench for the serial flash pin interface
`timescale 1ns/100ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin n_fail++; \
    $display("FAIL t=%0t got=%h exp=%h", $time, g, e); end end
module tb;
    logic clk = 1'b0;        // system clock
    logic reset = 1'b1;      // sync reset
    logic wp_n = 1'b1;       // write protect pin
    logic hw_reset_n = 1'b1; // reset pin
    wire  cs_n, sck, si, so, so_oe, standby, busy; // link pins and flags
    int   n_fail = 0;        // mismatches
    int   n_tests = 0;       // comparisons
    logic [7:0] q;           // byte read back
    always #20 clk = ~clk;
    spi_host_model host (.clk(clk), .cs_n(cs_n), .sck(sck), .si(si), .so(so), .so_oe(so_oe));
    serial_flash_pin_interface DUT (.clk(clk), .reset(reset), .cs_n(cs_n), .sck(sck),
        .si(si), .wp_n(wp_n), .hw_reset_n(hw_reset_n), .so(so), .so_oe(so_oe),
        .standby(standby), .busy(busy));
    task close_out;
        $display("tests=%0d fails=%0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // one frame: opcode then na zero bytes
    task cmd(input logic [7:0] op, input int na);
        host.start();
        host.xfer(op, q);
        repeat (na) host.xfer(8'h00, q);
        host.stop();
    endtask
    // status read compared against an expected byte
    task status(input logic [7:0] e);
        host.start();
        host.xfer(8'hD7, q);
        host.xfer(8'h00, q);
        host.stop();
        `CHK(q, e)
    endtask
    task t_idle;
        `CHK({standby, so_oe, busy}, 3'h4)
        host.noise();
        status(8'hC0);
    endtask
    // buffer write then read back in mode 3; A5 and 3C read the same in either bit order
    task t_buffer;
        host.mode3 = 1'b1;
        cmd(8'h84, 3);
        host.start();
        host.xfer(8'h84, q);
        repeat (3) host.xfer(8'h00, q);
        host.xfer(8'hA5, q);
        host.xfer(8'h3C, q);
        host.stop();
        host.start();
        host.xfer(8'hD4, q);
        repeat (4) host.xfer(8'h00, q);
        host.xfer(8'h00, q);
        `CHK(q, 8'hA5)
        host.xfer(8'h00, q);
        `CHK(q, 8'h3C)
        host.stop();
        host.mode3 = 1'b0;
    endtask
    // cut-off opcode must not leave stale counts behind
    task t_partial;
        host.nb = 3;
        cmd(8'hFF, 0);
        host.nb = 8;
        status(8'hC0);
    endtask
    task t_program;
        cmd(8'h83, 3);
        repeat (8) @(negedge clk);
        `CHK({busy, standby}, 2'h2)
        status(8'h40);
        for (int i = 0; i < 3000 && busy; i++) @(negedge clk);
        repeat (4) @(negedge clk);
        `CHK({busy, standby}, 2'h1)
    endtask
    task t_protect;
        // every sector marked while the pin is high, software protection off
        host.start();
        host.xfer(8'h3F, q);
        host.xfer(8'hFF, q);
        host.stop();
        // pin drops before the deselect that would start the program
        host.start();
        host.xfer(8'h83, q);
        repeat (3) host.xfer(8'h00, q);
        wp_n = 1'b0;
        host.stop();
        status(8'h90);
        cmd(8'h3F, 1);
        status(8'h90);
        cmd(8'h83, 3);
        repeat (8) @(negedge clk);
        `CHK({busy, standby}, 2'h1)
        status(8'h90);
        cmd(8'h3D, 0);
        status(8'hB0);
        wp_n = 1'b1;
        // mask written under a low pin must still be all ones
        cmd(8'h83, 3);
        repeat (8) @(negedge clk);
        `CHK({busy, standby}, 2'h1)
        cmd(8'h3F, 1);
    endtask
    task t_hw_reset;
        cmd(8'h81, 3);
        repeat (8) @(negedge clk);
        `CHK(busy, 1'b1)
        hw_reset_n = 1'b0;
        repeat (20) @(negedge clk);
        `CHK(busy, 1'b0)
        hw_reset_n = 1'b1;
        repeat (10) @(negedge clk);
        status(8'hE0);
        cmd(8'hA6, 0);
        status(8'hE1);
    endtask
    initial begin
        repeat (4) @(negedge clk);
        reset = 1'b0;
        repeat (24) @(negedge clk);
        t_idle();
        t_buffer();
        t_partial();
        t_program();
        t_protect();
        t_hw_reset();
        close_out();
    end
    // watchdog: the sequence needs well under 20000 clocks
    initial begin
        #2000000;
        n_fail++;
        close_out();
    end
endmodule // tb
bind serial_flash_pin_interface flash_pin_checker chk (.clk(clk), .reset(reset),
    .cs_n(cs_n), .sck(sck), .si(si), .wp_n(wp_n), .hw_reset_n(hw_reset_n), .so(so),
    .so_oe(so_oe), .standby(standby), .busy(busy));
